// >>> ftx_top.sv
// second four-tap transmitter lane with avalon register slave
//
// Our own choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module ftx_top #(
  parameter int PW = 12
) (
  input  wire logic          clock_i,
  input  wire logic          resetn_i,
  input  wire logic [3:0]    avs_address_i,
  input  wire logic          avs_read_i,
  input  wire logic          avs_write_i,
  input  wire logic [31:0]   avs_writedata_i,
  output logic      [31:0]   avs_readdata_o,
  output logic               avs_waitrequest_o,
  input  wire logic          pix_clk_i,
  input  wire logic          pix_resetn_i,
  input  wire logic          line_start_i,
  input  wire logic [PW-1:0] tap_two_stream_i,
  input  wire logic [PW-1:0] tap_three_stream_i,
  output logic      [7:0]    port_d_o,
  output logic      [7:0]    port_e_o,
  output logic      [7:0]    port_f_o,
  output logic               lval_o,
  output logic               dval_o,
  output logic               fval_o,
  output logic               spare_o
);
  localparam int CW = ftx_pkg::CNT_W;
  logic [6:0]    ctrl;
  logic [CW-1:0] roi_len;
  logic [CW-1:0] next_words;
  logic [CW-1:0] words;
  logic [31:0]   line_count;
  logic          done_sync;
  logic          done_q;
  logic          ack;
  logic [6:0]    ctrl_pix;
  logic [CW-1:0] words_pix;
  logic          done_tog;
  logic          lval_sync;

  // pixels per line for model and binning
  function automatic logic [CW-1:0] full_len(input logic [1:0] m, input logic b);
    logic [CW-1:0] n;
    case (m)
      ftx_pkg::MODEL_8K: n = CW'(ftx_pkg::LINE_8K);
      ftx_pkg::MODEL_4K: n = CW'(ftx_pkg::LINE_4K);
      default:           n = CW'(ftx_pkg::LINE_2K);
    endcase
    return b ? (n >> 1) : n;
  endfunction : full_len

  // words per line; region length overrides the full count
  always_comb begin
    if (ctrl[ftx_pkg::CTRL_ROI]) begin
      next_words = roi_len >> 2;
    end else begin
      next_words = full_len(ctrl[ftx_pkg::CTRL_MODEL +: 2], ctrl[ftx_pkg::CTRL_BIN]) >> 2;
    end
  end

  // one wait cycle per access keeps read data registered
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i || avs_write_i) && !ack;
    end
  end
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !ack);
    end
  end

  // register writes; settings only change between lines by software care
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl    <= '0;
      roi_len <= CW'(ftx_pkg::LINE_2K);
      words   <= '0;
    end else begin
      words <= next_words;
      if (avs_write_i && !avs_waitrequest_o) begin
        case (avs_address_i)
          ftx_pkg::REG_CTRL: ctrl    <= avs_writedata_i[6:0];
          ftx_pkg::REG_ROI:  roi_len <= avs_writedata_i[CW-1:0];
          default:           ctrl    <= ctrl;
        endcase
      end
    end
  end

  // read mux, unmapped returns a marker
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack) begin
      case (avs_address_i)
        ftx_pkg::REG_CTRL:   avs_readdata_o <= {25'h0, ctrl};
        ftx_pkg::REG_ROI:    avs_readdata_o <= {18'h0, roi_len};
        ftx_pkg::REG_STATUS: avs_readdata_o <= {17'h0, lval_sync, words};
        ftx_pkg::REG_COUNT:  avs_readdata_o <= line_count;
        default:             avs_readdata_o <= ftx_pkg::UNMAPPED;
      endcase
    end
  end

  // lines completed, counted from the link-side toggle
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_q     <= 1'b0;
      line_count <= '0;
    end else begin
      done_q <= done_sync;
      if (done_sync != done_q) begin
        line_count <= line_count + 32'h0000_0001;
      end
    end
  end

  // quasi-static settings cross as levels
  ftx_sync #(.W(7)) u_ctrl_sync (
    .clk_i    (pix_clk_i),
    .resetn_i (pix_resetn_i),
    .d_i      (ctrl),
    .q_o      (ctrl_pix)
  );
  ftx_sync #(.W(CW)) u_words_sync (
    .clk_i    (pix_clk_i),
    .resetn_i (pix_resetn_i),
    .d_i      (words),
    .q_o      (words_pix)
  );
  ftx_sync #(.W(1)) u_done_sync (
    .clk_i    (clock_i),
    .resetn_i (resetn_i),
    .d_i      (done_tog),
    .q_o      (done_sync)
  );
  // line valid is a link-side level; status reads it only after the synchroniser
  ftx_sync #(.W(1)) u_lval_sync (
    .clk_i    (clock_i),
    .resetn_i (resetn_i),
    .d_i      (lval_o),
    .q_o      (lval_sync)
  );

  ftx_lane #(.PW(PW)) u_lane (
    .pix_clk_i          (pix_clk_i),
    .pix_resetn_i       (pix_resetn_i),
    .start_i            (line_start_i),
    .depth_i            (ctrl_pix[ftx_pkg::CTRL_DEPTH +: 2]),
    .bin_i              (ctrl_pix[ftx_pkg::CTRL_BIN]),
    .jit_i              (ctrl_pix[ftx_pkg::CTRL_JIT]),
    .words_i            (words_pix),
    .tap_two_stream_i   (tap_two_stream_i),
    .tap_three_stream_i (tap_three_stream_i),
    .port_d_o           (port_d_o),
    .port_e_o           (port_e_o),
    .port_f_o           (port_f_o),
    .lval_o             (lval_o),
    .dval_o             (dval_o),
    .fval_o             (fval_o),
    .spare_o            (spare_o),
    .pix_idx_o          (),
    .done_tog_o         (done_tog)
  );

  words_full_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !ctrl[ftx_pkg::CTRL_ROI] && ctrl[ftx_pkg::CTRL_MODEL +: 2] == ftx_pkg::MODEL_8K
    && !ctrl[ftx_pkg::CTRL_BIN] && $stable(ctrl) |=> words == CW'(2048))
    else $error("8k line length wrong");
  words_bin_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !ctrl[ftx_pkg::CTRL_ROI] && ctrl[ftx_pkg::CTRL_MODEL +: 2] == ftx_pkg::MODEL_2K
    && ctrl[ftx_pkg::CTRL_BIN] && $stable(ctrl) |=> words == CW'(256))
    else $error("2k binned line length wrong");
  roi_len_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ctrl[ftx_pkg::CTRL_ROI] && $stable(ctrl) && $stable(roi_len)
    |=> words == ($past(roi_len) >> 2))
    else $error("region length ignored");
  bus_ack_a: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(avs_read_i) |-> ##1 !avs_waitrequest_o) else $error("read not answered");
  write_c: cover property (@(posedge clock_i) disable iff (!resetn_i)
    avs_write_i && !avs_waitrequest_o);
  count_c: cover property (@(posedge clock_i) disable iff (!resetn_i) line_count == 32'h0000_0002);
endmodule : ftx_top

// >>> ftx_pkg.sv
// constants and types of the second four-tap transmitter lane
package ftx_pkg;
  // output depth selection
  localparam logic [1:0] DEPTH_12 = 2'h0;
  localparam logic [1:0] DEPTH_10 = 2'h1;
  localparam logic [1:0] DEPTH_8  = 2'h2;
  // model width selection
  localparam logic [1:0] MODEL_2K = 2'h0;
  localparam logic [1:0] MODEL_4K = 2'h1;
  localparam logic [1:0] MODEL_8K = 2'h2;
  // full-resolution line lengths in pixels
  localparam int LINE_8K = 8192;
  localparam int LINE_4K = 4096;
  localparam int LINE_2K = 2048;
  localparam int TAPS    = 4;
  // pixel clock rate in kHz for converting delays
  localparam int LINK_KHZ = 40000;
  // 2k programmable 40 MHz delay window, nanoseconds
  localparam int DLY_MIN_NS     = 3180;
  localparam int DLY_MAX_NS     = 3310;
  localparam int DLY_BIN_MIN_NS = 10150;
  localparam int DLY_BIN_MAX_NS = 10280;
  localparam int DLY_MIN_CYC     = (DLY_MIN_NS * LINK_KHZ + 999999) / 1000000;
  localparam int DLY_MAX_CYC     = (DLY_MAX_NS * LINK_KHZ) / 1000000;
  localparam int DLY_BIN_MIN_CYC = (DLY_BIN_MIN_NS * LINK_KHZ + 999999) / 1000000;
  localparam int DLY_BIN_MAX_CYC = (DLY_BIN_MAX_NS * LINK_KHZ) / 1000000;
  localparam int CNT_W = 14;
  // register map, byte addresses
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_ROI    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hC;
  // control field positions
  localparam int CTRL_DEPTH = 0;
  localparam int CTRL_MODEL = 2;
  localparam int CTRL_BIN   = 4;
  localparam int CTRL_ROI   = 5;
  localparam int CTRL_JIT   = 6;
  localparam logic [31:0] UNMAPPED = 32'hDEAD_BEEF;
endpackage : ftx_pkg

// >>> ftx_sync.sv
// three-stage level synchroniser into a destination clock
`timescale 1ns/1ps
module ftx_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // only s2 reads s1; output updates once s2 and s3 agree
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1  <= '0;
      s2  <= '0;
      s3  <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule : ftx_sync

// >>> ftx_lane.sv
// link-clock side: line timing and port mapping of the second transmitter
`timescale 1ns/1ps
module ftx_lane #(
  parameter int PW = 12
) (
  input  wire logic                      pix_clk_i,
  input  wire logic                      pix_resetn_i,
  input  wire logic                      start_i,
  input  wire logic [1:0]                depth_i,
  input  wire logic                      bin_i,
  input  wire logic                      jit_i,
  input  wire logic [ftx_pkg::CNT_W-1:0] words_i,
  input  wire logic [PW-1:0]             tap_two_stream_i,
  input  wire logic [PW-1:0]             tap_three_stream_i,
  output logic [7:0]                     port_d_o,
  output logic [7:0]                     port_e_o,
  output logic [7:0]                     port_f_o,
  output logic                           lval_o,
  output logic                           dval_o,
  output logic                           fval_o,
  output logic                           spare_o,
  output logic [ftx_pkg::CNT_W-1:0]      pix_idx_o,
  output logic                           done_tog_o
);
  // elaboration check: the port map assumes 12 converter bits
  if (PW != 12) begin : g_pw_check
    $error("ftx_lane: converter width must be 12");
  end
  typedef enum logic [2:0] {
    LN_IDLE = 3'b001,
    LN_WAIT = 3'b010,
    LN_SEND = 3'b100
  } ftx_ln_t;
  ftx_ln_t                    st;
  logic [ftx_pkg::CNT_W-1:0]  cnt;
  logic [ftx_pkg::CNT_W-1:0]  dly_target;
  logic                       start_q;
  logic [2:0]                 lfsr;
  // pick delay inside the window; lfsr adds bounded line-to-line spread
  function automatic logic [ftx_pkg::CNT_W-1:0] pick_dly(input logic b, input logic [2:0] r,
                                                         input logic j);
    int lo;
    int hi;
    int v;
    lo = b ? ftx_pkg::DLY_BIN_MIN_CYC : ftx_pkg::DLY_MIN_CYC;
    hi = b ? ftx_pkg::DLY_BIN_MAX_CYC : ftx_pkg::DLY_MAX_CYC;
    v  = lo + (j ? int'(r) : 0);
    if (v > hi) v = hi;
    return ftx_pkg::CNT_W'(v);
  endfunction : pick_dly
  // line sequencer: delay, then words of four pixels
  always_ff @(posedge pix_clk_i or negedge pix_resetn_i) begin
    if (!pix_resetn_i) begin
      st         <= LN_IDLE;
      cnt        <= '0;
      dly_target <= '0;
      start_q    <= 1'b0;
      lfsr       <= 3'h1;
      lval_o     <= 1'b0;
      dval_o     <= 1'b0;
      pix_idx_o  <= '0;
      done_tog_o <= 1'b0;
    end else begin
      start_q <= start_i;
      lfsr    <= {lfsr[1:0], lfsr[2] ^ lfsr[1]};
      case (st)
        LN_IDLE: begin
          if (start_i && !start_q) begin
            dly_target <= pick_dly(bin_i, lfsr, jit_i);
            cnt        <= '0;
            st         <= LN_WAIT;
          end
        end
        LN_WAIT: begin
          cnt <= cnt + 1'b1;
          if (cnt + 1'b1 >= dly_target) begin
            cnt       <= '0;
            pix_idx_o <= ftx_pkg::CNT_W'(1);
            lval_o    <= 1'b1;
            dval_o    <= 1'b1;
            st        <= LN_SEND;
          end
        end
        LN_SEND: begin
          if (cnt + 1'b1 >= words_i) begin
            lval_o     <= 1'b0;
            dval_o     <= 1'b0;
            done_tog_o <= ~done_tog_o;
            st         <= LN_IDLE;
          end else begin
            cnt       <= cnt + 1'b1;
            pix_idx_o <= pix_idx_o + ftx_pkg::CNT_W'(ftx_pkg::TAPS);
          end
        end
        default: st <= LN_IDLE;
      endcase
    end
  end
  // port map per depth; inputs already hold converter msbs at bit 11
  always_ff @(posedge pix_clk_i or negedge pix_resetn_i) begin
    if (!pix_resetn_i) begin
      port_d_o <= '0;
      port_e_o <= '0;
      port_f_o <= '0;
    end else begin
      port_d_o <= '0;
      port_e_o <= '0;
      port_f_o <= '0;
      // last send edge clears the ports together with lval, so idle lanes read low
      if ((st == LN_SEND && cnt + 1'b1 < words_i) ||
          (st == LN_WAIT && cnt + 1'b1 >= dly_target)) begin
        case (depth_i)
          ftx_pkg::DEPTH_12: begin
            port_d_o <= tap_three_stream_i[7:0];
            port_e_o <= tap_two_stream_i[7:0];
            port_f_o <= {tap_three_stream_i[11:8], tap_two_stream_i[11:8]};
          end
          ftx_pkg::DEPTH_10: begin
            port_d_o <= tap_three_stream_i[9:2];
            port_e_o <= tap_two_stream_i[9:2];
            port_f_o <= {2'h0, tap_three_stream_i[11:10], 2'h0, tap_two_stream_i[11:10]};
          end
          ftx_pkg::DEPTH_8: begin
            port_d_o <= tap_three_stream_i[11:4];
          end
          default: port_d_o <= '0;
        endcase
      end
    end
  end
  // frame valid and spare stay low
  always_ff @(posedge pix_clk_i or negedge pix_resetn_i) begin
    if (!pix_resetn_i) begin
      fval_o  <= 1'b0;
      spare_o <= 1'b0;
    end else begin
      fval_o  <= 1'b0;
      spare_o <= 1'b0;
    end
  end

  lval_dval_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    lval_o == dval_o) else $error("line and data valid differ");
  idle_low_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    !lval_o |-> port_d_o == '0 && port_e_o == '0 && port_f_o == '0)
    else $error("idle port not low");
  step_four_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    lval_o && $past(lval_o) |-> pix_idx_o == $past(pix_idx_o) + ftx_pkg::CNT_W'(4))
    else $error("pixel index not advancing by four");
  first_pix_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    $rose(lval_o) |-> pix_idx_o == ftx_pkg::CNT_W'(1)) else $error("line not at pixel 1");
  dly_min_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    $rose(lval_o) |-> dly_target >= ftx_pkg::CNT_W'(ftx_pkg::DLY_MIN_CYC))
    else $error("delay under window");
  dly_max_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    st == LN_WAIT && !bin_i |-> dly_target <= ftx_pkg::CNT_W'(ftx_pkg::DLY_MAX_CYC))
    else $error("delay over window");
  eight_bit_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    depth_i == ftx_pkg::DEPTH_8 && $past(depth_i) == ftx_pkg::DEPTH_8 |-> port_e_o == '0)
    else $error("port e used in 8 bit");
  fval_low_a: assert property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    !fval_o && !spare_o) else $error("frame valid or spare driven");
  line_c: cover property (@(posedge pix_clk_i) disable iff (!pix_resetn_i) $fell(lval_o));
  bin_c: cover property (@(posedge pix_clk_i) disable iff (!pix_resetn_i) $rose(lval_o) && bin_i);
  d10_c: cover property (@(posedge pix_clk_i) disable iff (!pix_resetn_i)
    lval_o && depth_i == ftx_pkg::DEPTH_10);
endmodule : ftx_lane

// >>> ftx_grabber.sv
// frame grabber receiver model facing the second transmitter lane
`timescale 1ns/1ps
module ftx_grabber (
  input  wire logic       pix_clk_i,
  input  wire logic [7:0] port_d_i,
  input  wire logic [7:0] port_e_i,
  input  wire logic [7:0] port_f_i,
  input  wire logic       lval_i,
  input  wire logic       dval_i,
  output int              words_o,
  output int              lines_o,
  output logic [23:0]     word_o
);
  int   cnt  = 0;
  logic lv_q = 1'b0;

  initial begin
    words_o = 0;
    lines_o = 0;
    word_o  = 24'h00_0000;
  end

  // lane bits are only taken while both valid bits are high
  always @(posedge pix_clk_i) begin
    lv_q <= lval_i;
    if (lval_i === 1'b1 && dval_i === 1'b1) begin
      cnt    <= cnt + 1;
      word_o <= {port_f_i, port_e_i, port_d_i};
    end
    // end of line: publish the count, ready for the next one
    if (lv_q === 1'b1 && lval_i !== 1'b1) begin
      words_o <= cnt;
      lines_o <= lines_o + 1;
      cnt     <= 0;
    end
  end
endmodule : ftx_grabber

// >>> ftx_top_test.sv
// self-checking bench of the second four-tap transmitter lane
`timescale 1ns/1ps
module ftx_top_test;
  typedef struct {
    logic [1:0]  depth;
    logic [1:0]  model;
    logic        bin;
    logic        roi;
    logic        jit;
    logic [31:0] roi_px;
    int          words;
    logic [11:0] t2;
    logic [11:0] t3;
  } ftx_row_t;

  // every depth and model, binned and not, one region line
  ftx_row_t rows [7] = '{
    '{2'h0, 2'h0, 0, 0, 0, 32'h0000_0800, 512, 12'hA5C, 12'h3E1},
    '{2'h1, 2'h1, 0, 0, 1, 32'h0000_0800, 1024, 12'h5A3, 12'hC1E},
    '{2'h2, 2'h2, 0, 0, 0, 32'h0000_0800, 2048, 12'hF0F, 12'h9B7},
    '{2'h0, 2'h2, 1, 0, 1, 32'h0000_0800, 1024, 12'h1C7, 12'hE38},
    '{2'h1, 2'h0, 1, 0, 0, 32'h0000_0800, 256, 12'hFFF, 12'h801},
    '{2'h2, 2'h1, 1, 0, 0, 32'h0000_0800, 512, 12'h7FE, 12'h4D2},
    '{2'h0, 2'h0, 0, 1, 0, 32'h0000_0066, 25, 12'h0F3, 12'hB2C}};

  logic        clock_i         = 1'b0;
  logic        resetn_i        = 1'b0;
  logic        pix_clk_i       = 1'b0;
  logic        pix_resetn_i    = 1'b0;
  logic [3:0]  avs_address_i   = 4'h0;
  logic        avs_read_i      = 1'b0;
  logic        avs_write_i     = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic        line_start_i    = 1'b0;
  logic [11:0] t2              = 12'h000;
  logic [11:0] t3              = 12'h000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  port_d_o;
  logic [7:0]  port_e_o;
  logic [7:0]  port_f_o;
  logic        lval_o;
  logic        dval_o;
  logic        fval_o;
  logic        spare_o;
  int          g_words;
  int          g_lines;
  logic [23:0] g_word;
  int          fails       = 0;
  int          check_count = 0;

  ftx_top #(.PW(12)) dut_u (
    .clock_i(clock_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .pix_clk_i(pix_clk_i),
    .pix_resetn_i(pix_resetn_i), .line_start_i(line_start_i),
    .tap_two_stream_i(t2), .tap_three_stream_i(t3), .port_d_o(port_d_o),
    .port_e_o(port_e_o), .port_f_o(port_f_o), .lval_o(lval_o), .dval_o(dval_o),
    .fval_o(fval_o), .spare_o(spare_o));

  ftx_grabber grab_u (
    .pix_clk_i(pix_clk_i), .port_d_i(port_d_o), .port_e_i(port_e_o),
    .port_f_i(port_f_o), .lval_i(lval_o), .dval_i(dval_o),
    .words_o(g_words), .lines_o(g_lines), .word_o(g_word));

  // system clock and an unrelated link clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  initial begin
    #7;
    forever #16 pix_clk_i = ~pix_clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic chk_in(input int n, input int lo, input int hi, input string m);
    check_count++;
    if (n < lo || n > hi) begin
      fails++;
      $display("[ERR] %0t %s %0d outside %0d..%0d", $time, m, n, lo, hi);
    end
  endtask : chk_in

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic give_up(input string m);
    fails++;
    $display("[ERR] %0t wait ran out: %s", $time, m);
    print_verdict();
  endtask : give_up

  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge clock_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clock_i);
      if (avs_waitrequest_o === 1'b0) break;
    end
    if (k == 50) give_up("bus");
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus

  // expected {F, E, D} for tap three sample a and tap two sample b
  function automatic logic [23:0] map(input logic [1:0] dp, input logic [11:0] a,
                                      input logic [11:0] b);
    case (dp)
      ftx_pkg::DEPTH_12: return {a[11:8], b[11:8], b[7:0], a[7:0]};
      ftx_pkg::DEPTH_10: return {2'b00, a[11:10], 2'b00, b[11:10], b[9:2], a[9:2]};
      default:           return {16'h0000, a[11:4]};
    endcase
  endfunction : map

  // one line; lo of zero skips the delay window, retrig pulses start again mid-line and expects no second line
  task automatic run_line(input int words, input logic [23:0] exp, input int lo,
                          input int hi, input logic retrig);
    int n;
    int l0;
    l0 = g_lines;
    @(posedge pix_clk_i);
    line_start_i <= 1'b1;
    for (n = 0; n < 1000 && lval_o !== 1'b1; n++) @(posedge pix_clk_i);
    if (n == 1000) give_up("line valid");
    // the start sampling edge and this loop's own sampling add two cycles
    if (lo > 0) chk_in(n - 2, lo, hi, "delay");
    if (retrig) begin
      repeat (3) @(posedge pix_clk_i);
      line_start_i <= 1'b0;
      @(posedge pix_clk_i);
      line_start_i <= 1'b1;
    end
    for (n = 0; n < 3000 && lval_o === 1'b1; n++) begin
      chk({30'h0, fval_o | spare_o, dval_o}, 32'h0000_0001, "valid bits");
      @(posedge pix_clk_i);
      line_start_i <= 1'b0;
    end
    if (n == 3000) give_up("line end");
    repeat (4) @(posedge pix_clk_i);
    chk(g_words, words, "words");
    chk({8'h00, g_word}, {8'h00, exp}, "lane bits");
    chk(g_lines, l0 + 1, "lines");
    if (retrig) begin
      for (n = 0; n < 450; n++) begin
        @(posedge pix_clk_i);
        if (lval_o === 1'b1) give_up("second line from refused start");
      end
    end
  endtask : run_line

  initial begin
    logic [31:0] v;
    int          lo;
    int          hi;
    ftx_row_t    r;
    repeat (3) @(posedge clock_i);
    resetn_i     <= 1'b1;
    pix_resetn_i <= 1'b1;
    repeat (8) @(posedge pix_clk_i);
    for (int i = 0; i < 7; i++) begin
      r = rows[i];
      bus(1'b1, ftx_pkg::REG_ROI, r.roi_px, v);
      bus(1'b1, ftx_pkg::REG_CTRL, {25'h0, r.jit, r.roi, r.bin, r.model, r.depth}, v);
      repeat (10) @(posedge pix_clk_i);
      bus(1'b0, ftx_pkg::REG_STATUS, 32'h0000_0000, v);
      chk({18'h0, v[13:0]}, r.words, "status words");
      t2 <= r.t2;
      t3 <= r.t3;
      lo = r.roi ? 0 : (r.bin ? ftx_pkg::DLY_BIN_MIN_CYC : ftx_pkg::DLY_MIN_CYC);
      hi = r.bin ? ftx_pkg::DLY_BIN_MAX_CYC : ftx_pkg::DLY_MAX_CYC;
      repeat (2) run_line(r.words, map(r.depth, r.t3, r.t2), lo, hi, 1'b0);
    end
    // read-only status ignores writes; unmapped reads give the filler
    bus(1'b1, ftx_pkg::REG_STATUS, 32'h0000_0000, v);
    bus(1'b0, ftx_pkg::REG_STATUS, 32'h0000_0000, v);
    chk({18'h0, v[13:0]}, 32'h0000_0019, "status kept");
    bus(1'b0, 4'h2, 32'h0000_0000, v);
    chk(v, ftx_pkg::UNMAPPED, "unmapped");
    // a start while a line is in flight is dropped
    bus(1'b0, ftx_pkg::REG_COUNT, 32'h0000_0000, v);
    lo = v;
    run_line(25, map(2'h0, 12'hB2C, 12'h0F3), 0, 0, 1'b1);
    bus(1'b0, ftx_pkg::REG_COUNT, 32'h0000_0000, v);
    chk(v, lo + 1, "line count");
    // reset in mid-line clears the lane and the bus
    @(posedge pix_clk_i);
    line_start_i <= 1'b1;
    repeat (140) @(posedge pix_clk_i);
    bus(1'b0, ftx_pkg::REG_STATUS, 32'h0000_0000, v);
    chk({31'h0, v[14]}, 32'h0000_0001, "status line valid");
    @(posedge clock_i);
    resetn_i     <= 1'b0;
    pix_resetn_i <= 1'b0;
    line_start_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk({avs_waitrequest_o, avs_readdata_o[30:0]}, 32'h8000_0000, "bus in reset");
    chk({port_d_o, port_e_o, port_f_o, lval_o, dval_o}, 32'h0000_0000, "lane in reset");
    resetn_i     <= 1'b1;
    pix_resetn_i <= 1'b1;
    repeat (8) @(posedge pix_clk_i);
    bus(1'b0, ftx_pkg::REG_ROI, 32'h0000_0000, v);
    chk(v, 32'h0000_0800, "region reset value");
    print_verdict();
  end
endmodule : ftx_top_test
